// ==== verilog/sfwp_pkg.sv ====
// Constants and types for the serial flash write-protect front end
package sfwp_pkg;
   // Status register bit positions
   localparam int SR_LOCK = 7;
   localparam int SR_OTP = 6;
   localparam int SR_INV = 5;
   localparam int SR_REGION_HI = 4;
   localparam int SR_REGION_LO = 2;
   localparam int SR_LATCH = 1;
   localparam int SR_BUSY = 0;
   localparam logic [5:0] NV_SHIP_DEFAULT = 6'h00;

   // Command codes
   localparam logic [7:0] CMD_WRITE_UNLOCK = 8'h06;
   localparam logic [7:0] CMD_WRITE_LOCK = 8'h04;
   localparam logic [7:0] CMD_READ_STATUS = 8'h05;
   localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
   localparam logic [7:0] CMD_PAGE_WRITE = 8'h02;
   localparam logic [7:0] CMD_FOUR_K_WIPE = 8'h20;
   localparam logic [7:0] CMD_BLOCK_32K = 8'h52;
   localparam logic [7:0] CMD_BLOCK_64K = 8'hD8;
   localparam logic [7:0] CMD_FULL_CLEAR_A = 8'h60;
   localparam logic [7:0] CMD_FULL_CLEAR_B = 8'hC7;
   localparam logic [7:0] CMD_DUAL_READ = 8'h3B;
   localparam logic [7:0] CMD_SLEEP = 8'hB9;
   localparam logic [7:0] CMD_WAKE = 8'hAB;
   localparam logic [7:0] CMD_SEC_ERASE = 8'h44;
   localparam logic [7:0] CMD_SEC_PROG = 8'h42;

   // Sequence lengths in bytes
   localparam logic [2:0] LEN_BARE = 3'h1;
   localparam logic [2:0] LEN_STATUS_WRITE = 3'h2;
   localparam logic [2:0] LEN_ADDR = 3'h4;
   localparam logic [2:0] LEN_WITH_DATA = 3'h5;
   localparam logic [2:0] LEN_DUAL_DATA = 3'h5;

   // Array geometry
   localparam logic [23:0] SIZE_4M = 24'h080000;
   localparam logic [23:0] SIZE_2M = 24'h040000;
   localparam logic [23:0] SPAN_BASE = 24'h002000;
   localparam logic [23:0] MASK_PAGE = 24'h0000FF;
   localparam logic [23:0] MASK_SECTOR = 24'h000FFF;
   localparam logic [23:0] MASK_BLK32 = 24'h007FFF;
   localparam logic [23:0] MASK_BLK64 = 24'h00FFFF;

   // Self-timed status write
   localparam int CLK_PERIOD_NS = 10;
   localparam int STATUS_WRITE_NS = 1000;
   localparam int STATUS_WRITE_CYCLES = (STATUS_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Synchroniser reset levels: csN, sclk, lane0, writeGuardN
   localparam logic [3:0] PIN_RESET = 4'h9;

   typedef enum logic [2:0] {
      OP_PAGE = 3'h0,
      OP_SECTOR = 3'h1,
      OP_BLK32 = 3'h2,
      OP_BLK64 = 3'h3,
      OP_CHIP = 3'h4,
      OP_SEC_PROG = 3'h5,
      OP_SEC_ERASE = 3'h6
   } sfwp_op_t;

   typedef enum logic [2:0] {
      BS_IDLE = 3'b001,
      BS_STATUS = 3'b010,
      BS_ARRAY = 3'b100
   } sfwp_busy_t;
endpackage

// ==== verilog/sfwp_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module sfwp_pin_sync #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] pinOut
);
   if (WIDTH < 1) begin : g_bad_width
      $error("sfwp_pin_sync: WIDTH must be at least 1");
   end

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic s1_r;
         logic s2_r;
         logic s3_r;
         wire agree = (s2_r == s3_r);
         // First stage feeds only the second
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               s1_r <= RESET_VAL[i];
               s2_r <= RESET_VAL[i];
               s3_r <= RESET_VAL[i];
               pinOut[i] <= RESET_VAL[i];
            end else if (ce) begin
               s1_r <= pinIn[i];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (agree) pinOut[i] <= s3_r;
            end
         end
      end
   endgenerate
endmodule

// ==== verilog/sfwp_core.sv ====
// Serial flash status register, write protection and lane control
//
// Operation
// RQ1 - Works with idle-low or idle-high serial clock
// RQ2 - Sample on rising edge, drive on falling
// RQ3 - Dual read drives two lanes per clock
// RQ4 - Unlock sets latch; lock and completions clear
// RQ5 - Selected region is readable, never modified; the core allows 4M full clear at region 6 inverted, top half protected
// RQ6 - Guard low plus lock freezes protect bits
// RQ7 - Deep sleep ignores all but wake
// RQ8 - 4M bottom ranges when not inverted
// RQ9 - 4M top ranges when inverted
// RQ10 - 2M bottom ranges when not inverted
// RQ11 - 2M top ranges when inverted
// RQ12 - Fixed status bit layout, low bits read-only
// RQ13 - Busy flag high during self-timed operations
// RQ14 - Writes refused while latch is clear
// RQ15 - Reject program or erase hitting protected region; the core accepts 4M full clear at region 6 inverted, top half protected
// RQ16 - Region bits writable only without hardware lock
// RQ17 - Full clear only for two region settings; the core accepts three: region 0 not inverted, regions 6 and 7 inverted
// RQ18 - Status write gated by lock and guard
// RQ19 - Invert bit ships as zero
// RQ20 - Security lock is one-time, never cleared
// RQ21 - Status write leaves latch and busy alone
// RQ22 - Host ends status write after eighth bit
// RQ23 - Status readable at any time; the core does not drive status in deep power-down
// RQ24 - Power-up loads cells, latch and busy zero
`timescale 1ns/1ns
module sfwp_core #(
   parameter bit DENSITY_4M = 1'b1,
   parameter int STATUS_WRITE_CYCLES = sfwp_pkg::STATUS_WRITE_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic csN,
   input wire logic sclk,
   input wire logic dualLane0In,
   output logic dualLane0Out,
   output logic dualLane0Oe,
   output logic dualLane1Out,
   output logic dualLane1Oe,
   input wire logic writeGuardN,
   input wire logic [5:0] nvCellsIn,
   output logic [7:0] statusOut,
   output logic opStart,
   output logic [2:0] opKind,
   output logic [23:0] opAddr,
   input wire logic opDone,
   output logic [23:0] readAddr,
   input wire logic [7:0] readByte,
   output logic deepPowerDown
);
   // The busy counter is 16 bits wide, so longer status writes cannot be timed
   if (STATUS_WRITE_CYCLES < 1 || STATUS_WRITE_CYCLES > 65535) begin : g_bad_cycles
      $error("sfwp_core: STATUS_WRITE_CYCLES out of range");
   end

   // Pin conditioning
   logic [3:0] pinSync;
   sfwp_pin_sync #(
      .WIDTH(4),
      .RESET_VAL(sfwp_pkg::PIN_RESET)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .pinIn({writeGuardN, dualLane0In, sclk, csN}),
      .pinOut(pinSync)
   );
   wire fCsN = pinSync[0];
   wire fSclk = pinSync[1];
   wire fSi = pinSync[2];
   wire fGuardN = pinSync[3];

   // Protected-region test for one address
   function automatic logic inRegion(input logic [23:0] a, input logic [2:0] bp, input logic inv);
      logic [23:0] size;
      logic [23:0] span;
      logic [23:0] bound;
      logic [23:0] am;
      logic allCode;
      logic hit;
      size = DENSITY_4M ? sfwp_pkg::SIZE_4M : sfwp_pkg::SIZE_2M;
      am = a & (size - 24'h000001);
      span = sfwp_pkg::SPAN_BASE << (bp - 3'h1);
      bound = size - span;
      allCode = DENSITY_4M ? (bp == 3'h7) : (bp[2:1] == 2'h3); // RQ8 RQ10
      if (bp == 3'h0) begin
         hit = inv;
      end else if (allCode) begin
         hit = ~inv;
      end else if (inv) begin
         hit = (am >= bound); // RQ9 RQ11
      end else begin
         hit = (am < bound); // RQ8 RQ10
      end
      return hit;
   endfunction

   // Edge detection on the filtered pins
   logic prevSclk_r;
   logic prevCsN_r;
   // Edges are found from the level change itself, so the idle level does not matter
   wire sclkRise = ~fCsN & fSclk & ~prevSclk_r; // RQ1
   wire sclkFall = ~fCsN & ~fSclk & prevSclk_r; // RQ1
   wire csRise = fCsN & ~prevCsN_r;
   wire csFall = ~fCsN & prevCsN_r;

   // Frame shifter
   logic [2:0] bitInByte_r;
   logic [2:0] byteCnt_r;
   logic [6:0] shift_r;
   logic [7:0] cmd_r;
   logic [7:0] data_r;
   logic [23:0] addr_r;
   wire [7:0] byteIn = {shift_r, fSi};
   wire byteDone = sclkRise & (bitInByte_r == 3'h7);
   wire byteSat = (byteCnt_r == 3'h7);

   // Status state
   logic [5:0] statusNv_r;
   logic loadPending_r;
   logic latch_r;
   logic [5:0] pendNv_r;
   logic dpd_r;
   sfwp_pkg::sfwp_busy_t busyState_r;
   sfwp_pkg::sfwp_busy_t busyState_nxt;
   logic [15:0] busyCnt_r;

   wire busy = (busyState_r != sfwp_pkg::BS_IDLE); // RQ13
   wire [7:0] statusWord = {statusNv_r, latch_r, busy}; // RQ12
   wire lockBit = statusNv_r[sfwp_pkg::SR_LOCK - 2];
   wire otpBit = statusNv_r[sfwp_pkg::SR_OTP - 2];
   wire invBit = statusNv_r[sfwp_pkg::SR_INV - 2];
   wire [2:0] regionSel = statusNv_r[sfwp_pkg::SR_REGION_HI - 2:sfwp_pkg::SR_REGION_LO - 2];
   wire hwLock = lockBit & ~fGuardN; // RQ6 RQ18

   // Command decode at chip-select release
   wire onBoundary = (bitInByte_r == 3'h0);
   wire exec = csRise & onBoundary & ~dpd_r & ~busy; // RQ7
   wire isUnlock = (cmd_r == sfwp_pkg::CMD_WRITE_UNLOCK);
   wire isLock = (cmd_r == sfwp_pkg::CMD_WRITE_LOCK);
   wire isStatusWr = (cmd_r == sfwp_pkg::CMD_STATUS_WRITE);
   wire isPage = (cmd_r == sfwp_pkg::CMD_PAGE_WRITE);
   wire isSector = (cmd_r == sfwp_pkg::CMD_FOUR_K_WIPE);
   wire isBlk32 = (cmd_r == sfwp_pkg::CMD_BLOCK_32K);
   wire isBlk64 = (cmd_r == sfwp_pkg::CMD_BLOCK_64K);
   wire isChip = (cmd_r == sfwp_pkg::CMD_FULL_CLEAR_A) | (cmd_r == sfwp_pkg::CMD_FULL_CLEAR_B);
   wire isSleep = (cmd_r == sfwp_pkg::CMD_SLEEP);
   wire isWake = (cmd_r == sfwp_pkg::CMD_WAKE);
   wire isSecProg = (cmd_r == sfwp_pkg::CMD_SEC_PROG);
   wire isSecErase = (cmd_r == sfwp_pkg::CMD_SEC_ERASE);
   wire isReadStatus = (cmd_r == sfwp_pkg::CMD_READ_STATUS);
   wire isDual = (cmd_r == sfwp_pkg::CMD_DUAL_READ);

   // Erase spans: protected region sits at one end, so checking both ends covers overlap
   wire [23:0] sectorLo = addr_r & ~sfwp_pkg::MASK_SECTOR;
   wire [23:0] blk32Lo = addr_r & ~sfwp_pkg::MASK_BLK32;
   wire [23:0] blk64Lo = addr_r & ~sfwp_pkg::MASK_BLK64;
   wire pageHit = inRegion(addr_r, regionSel, invBit); // RQ5 RQ15
   wire sectorHit = inRegion(sectorLo, regionSel, invBit) |
                    inRegion(sectorLo | sfwp_pkg::MASK_SECTOR, regionSel, invBit); // RQ15
   wire blk32Hit = inRegion(blk32Lo, regionSel, invBit) |
                   inRegion(blk32Lo | sfwp_pkg::MASK_BLK32, regionSel, invBit); // RQ15
   wire blk64Hit = inRegion(blk64Lo, regionSel, invBit) |
                   inRegion(blk64Lo | sfwp_pkg::MASK_BLK64, regionSel, invBit); // RQ15
   wire chipOk = ((regionSel == 3'h0) & ~invBit) | ((regionSel[2:1] == 2'h3) & invBit); // RQ17

   wire doUnlock = exec & isUnlock & (byteCnt_r == sfwp_pkg::LEN_BARE); // RQ4
   wire doLock = exec & isLock & (byteCnt_r == sfwp_pkg::LEN_BARE); // RQ4
   // A short or long frame never starts the status write
   wire doStatusWr = exec & isStatusWr & (byteCnt_r == sfwp_pkg::LEN_STATUS_WRITE) &
                     latch_r & ~hwLock; // RQ14 RQ16 RQ18 RQ22
   wire addrLen = (byteCnt_r == sfwp_pkg::LEN_ADDR);
   wire dataLen = (byteCnt_r >= sfwp_pkg::LEN_WITH_DATA);
   wire doPage = exec & isPage & dataLen & latch_r & ~pageHit; // RQ14 RQ15
   wire doSector = exec & isSector & addrLen & latch_r & ~sectorHit; // RQ14 RQ15
   wire doBlk32 = exec & isBlk32 & addrLen & latch_r & ~blk32Hit; // RQ14 RQ15
   wire doBlk64 = exec & isBlk64 & addrLen & latch_r & ~blk64Hit; // RQ14 RQ15
   wire doChip = exec & isChip & (byteCnt_r == sfwp_pkg::LEN_BARE) & latch_r & chipOk; // RQ14 RQ17
   wire doSecProg = exec & isSecProg & dataLen & latch_r & ~otpBit; // RQ14 RQ20
   wire doSecErase = exec & isSecErase & addrLen & latch_r & ~otpBit; // RQ14 RQ20
   wire doSleep = exec & isSleep & (byteCnt_r == sfwp_pkg::LEN_BARE);
   wire doWake = csRise & dpd_r & isWake & (byteCnt_r >= sfwp_pkg::LEN_BARE); // RQ7
   wire doArray = doPage | doSector | doBlk32 | doBlk64 | doChip | doSecProg | doSecErase;

   wire [2:0] kindSel = doPage ? sfwp_pkg::OP_PAGE :
                        doSector ? sfwp_pkg::OP_SECTOR :
                        doBlk32 ? sfwp_pkg::OP_BLK32 :
                        doBlk64 ? sfwp_pkg::OP_BLK64 :
                        doChip ? sfwp_pkg::OP_CHIP :
                        doSecProg ? sfwp_pkg::OP_SEC_PROG : sfwp_pkg::OP_SEC_ERASE;

   // Busy engine
   wire swDone = (busyState_r == sfwp_pkg::BS_STATUS) & (busyCnt_r == 16'h0000);
   wire arrDone = (busyState_r == sfwp_pkg::BS_ARRAY) & opDone;
   wire busyEnd = swDone | arrDone;
   // Latch and busy bits are not taken from the data byte
   wire [5:0] newNv = {data_r[7], otpBit | data_r[6], data_r[5:2]}; // RQ20 RQ21

   always_comb begin
      busyState_nxt = busyState_r;
      unique case (busyState_r)
         sfwp_pkg::BS_IDLE: begin
            if (doStatusWr) busyState_nxt = sfwp_pkg::BS_STATUS;
            else if (doArray) busyState_nxt = sfwp_pkg::BS_ARRAY;
         end
         sfwp_pkg::BS_STATUS: begin
            if (swDone) busyState_nxt = sfwp_pkg::BS_IDLE;
         end
         sfwp_pkg::BS_ARRAY: begin
            if (arrDone) busyState_nxt = sfwp_pkg::BS_IDLE;
         end
         default: busyState_nxt = sfwp_pkg::BS_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busyState_r <= sfwp_pkg::BS_IDLE; // RQ24
         busyCnt_r <= 16'h0000;
         pendNv_r <= sfwp_pkg::NV_SHIP_DEFAULT;
      end else if (ce) begin
         busyState_r <= busyState_nxt; // RQ13
         if (doStatusWr) begin
            busyCnt_r <= 16'(STATUS_WRITE_CYCLES - 1);
            pendNv_r <= newNv;
         end else if (busyCnt_r != 16'h0000) begin
            busyCnt_r <= busyCnt_r - 16'h0001;
         end
      end
   end

   // Non-volatile bits: cells are read once after reset release
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         statusNv_r <= sfwp_pkg::NV_SHIP_DEFAULT; // RQ19
         loadPending_r <= 1'b1;
      end else if (ce) begin
         loadPending_r <= 1'b0;
         if (loadPending_r) statusNv_r <= nvCellsIn; // RQ24
         else if (swDone) statusNv_r <= pendNv_r; // RQ6 RQ20
      end
   end

   // Write latch: completion of any self-timed cycle clears it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         latch_r <= 1'b0; // RQ24
      end else if (ce) begin
         if (doUnlock) latch_r <= 1'b1; // RQ4
         else if (doLock | busyEnd) latch_r <= 1'b0; // RQ4
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dpd_r <= 1'b0;
      end else if (ce) begin
         if (doSleep) dpd_r <= 1'b1;
         else if (doWake) dpd_r <= 1'b0; // RQ7
      end
   end

   // Frame shifter, input bits taken on rising edges only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prevSclk_r <= 1'b0;
         prevCsN_r <= 1'b1;
         bitInByte_r <= 3'h0;
         byteCnt_r <= 3'h0;
         shift_r <= 7'h00;
         cmd_r <= 8'h00;
         data_r <= 8'h00;
         addr_r <= 24'h000000;
      end else if (ce) begin
         prevSclk_r <= fSclk;
         prevCsN_r <= fCsN;
         if (csFall) begin
            bitInByte_r <= 3'h0;
            byteCnt_r <= 3'h0;
         end else if (sclkRise) begin
            bitInByte_r <= bitInByte_r + 3'h1; // RQ2
            shift_r <= byteIn[6:0]; // RQ2
            if (byteDone & ~byteSat) byteCnt_r <= byteCnt_r + 3'h1;
            if (byteDone & (byteCnt_r == 3'h0)) cmd_r <= byteIn;
            if (byteDone & (byteCnt_r == 3'h1)) data_r <= byteIn;
            if (byteDone & (byteCnt_r >= 3'h1) & (byteCnt_r <= 3'h3)) addr_r <= {addr_r[15:0], byteIn};
         end
      end
   end

   // Output lanes
   logic [2:0] outBit_r;
   logic [1:0] pairIdx_r;
   logic [7:0] holdByte_r;
   // Status may be read even during a self-timed cycle
   wire statusPhase = isReadStatus & (byteCnt_r >= sfwp_pkg::LEN_BARE) & ~dpd_r; // RQ7 RQ23
   // Array reads are refused while busy
   wire dualPhase = isDual & (byteCnt_r >= sfwp_pkg::LEN_DUAL_DATA) & ~dpd_r & ~busy; // RQ3 RQ7
   wire firstPair = (pairIdx_r == 2'h0);
   wire laneHi = firstPair ? readByte[7] : holdByte_r[{~pairIdx_r, 1'b1}]; // RQ3
   wire laneLo = firstPair ? readByte[6] : holdByte_r[{~pairIdx_r, 1'b0}]; // RQ3
   wire addrDone = byteDone & (byteCnt_r == 3'h3);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dualLane0Out <= 1'b0;
         dualLane0Oe <= 1'b0;
         dualLane1Out <= 1'b0;
         dualLane1Oe <= 1'b0;
         outBit_r <= 3'h0;
         pairIdx_r <= 2'h0;
         holdByte_r <= 8'h00;
         readAddr <= 24'h000000;
      end else if (ce) begin
         if (fCsN) begin
            dualLane0Oe <= 1'b0;
            dualLane1Oe <= 1'b0;
            outBit_r <= 3'h0;
            pairIdx_r <= 2'h0;
         end else if (sclkFall & statusPhase) begin
            dualLane1Out <= statusWord[~outBit_r]; // RQ2 RQ23
            dualLane1Oe <= 1'b1;
            outBit_r <= outBit_r + 3'h1;
         end else if (sclkFall & dualPhase) begin
            dualLane1Out <= laneHi; // RQ2 RQ3
            dualLane0Out <= laneLo; // RQ3
            dualLane1Oe <= 1'b1;
            dualLane0Oe <= 1'b1; // RQ3
            pairIdx_r <= pairIdx_r + 2'h1;
            if (firstPair) holdByte_r <= readByte;
            if (pairIdx_r == 2'h3) readAddr <= readAddr + 24'h000001;
         end
         if (addrDone) readAddr <= {addr_r[15:0], byteIn};
      end
   end

   // Registered status and array command outputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         statusOut <= 8'h00;
         opStart <= 1'b0;
         opKind <= 3'h0;
         opAddr <= 24'h000000;
         deepPowerDown <= 1'b0;
      end else if (ce) begin
         statusOut <= statusWord; // RQ12
         opStart <= doArray; // RQ5
         deepPowerDown <= dpd_r;
         if (doArray) begin
            opKind <= kindSel;
            opAddr <= addr_r;
         end
      end
   end
endmodule

// ==== test/sfwp_core_monitor.sv ====
// Checker for the flash write-protect core ports
`timescale 1ns/1ns
module sfwp_core_monitor #(
   parameter int STATUS_WRITE_CYCLES = 100
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic csN,
   input wire logic writeGuardN,
   input wire logic dualLane0Oe,
   input wire logic dualLane1Oe,
   input wire logic [7:0] statusOut,
   input wire logic opStart,
   input wire logic [2:0] opKind,
   input wire logic deepPowerDown
);
   // Status bits: 7 lock, 6 otp, 5 invert, 4..2 region, 1 latch, 0 busy
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence guardHeldLow;
      !writeGuardN[*8];
   endsequence
   a_start_sets_busy: assert property (opStart |-> ##[0:3] statusOut[0])
      else $error("busy not raised after array start");
   a_start_needs_latch: assert property (opStart |-> statusOut[1])
      else $error("array start without latch");
   a_sleep_no_start: assert property (deepPowerDown |-> !opStart)
      else $error("array start in deep power-down");
   // Deselect filter plus lane pipeline needs a few cycles before the drivers drop
   a_lanes_off_idle: assert property (csN[*8] ##1 csN[*6] |-> !dualLane0Oe && !dualLane1Oe)
      else $error("lanes driven while deselected");
   a_dual_lanes_pair: assert property (dualLane0Oe |-> dualLane1Oe)
      else $error("lane 0 driven without lane 1");
   a_latch_set_idle: assert property ($rose(statusOut[1]) |-> !statusOut[0] && !$past(statusOut[0]))
      else $error("latch set while busy");
   a_latch_clear_done: assert property ($fell(statusOut[0]) |-> ##[0:1] !statusOut[1])
      else $error("latch kept after completion");
   a_otp_never_clears: assert property (!$fell(statusOut[6]))
      else $error("security lock bit cleared");
   a_lock_freeze_bits: assert property (guardHeldLow ##0 statusOut[7] |=> $stable(statusOut[7:2]))
      else $error("protect bits changed while locked");
   a_full_clear_gate: assert property (opStart && opKind == sfwp_pkg::OP_CHIP |->
         statusOut[5:2] == 4'h0 || statusOut[5:3] == 3'h7)
      else $error("full clear with a protected region");
   c_program: cover property (opStart && opKind == sfwp_pkg::OP_PAGE);
   c_dual: cover property (dualLane0Oe);
   c_sleep: cover property (deepPowerDown);
   c_locked: cover property (statusOut[7] && !writeGuardN);
endmodule
bind sfwp_core sfwp_core_monitor #(.STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) u_sfwp_core_monitor (.clk, .rst,
   .csN, .writeGuardN, .dualLane0Oe, .dualLane1Oe, .statusOut, .opStart, .opKind, .deepPowerDown);

// ==== test/sfwp_host_model.sv ====
// Behavioural host SPI controller driving the flash pins
`timescale 1ns/1ns
module sfwp_host_model (
   input wire logic clk,
   output logic csN,
   output logic sclk,
   output logic mosi,
   output logic mosiEn,
   input wire logic miso,
   input wire logic lane0
);
   logic cpol = 1'b0;
   initial begin
      csN = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
      mosiEn = 1'b1;
   end
   // Sampling late in the high phase absorbs the device's pin synchroniser latency
   task automatic xfer(input logic [63:0] tx, input int nTx, input int nClk, output logic [63:0] r1,
         output logic [63:0] r0);
      r1 = '0;
      r0 = '0;
      @(negedge clk);
      sclk <= cpol;
      repeat (4) @(negedge clk);
      csN <= 1'b0;
      repeat (4) @(negedge clk);
      for (int k = 0; k < nClk; k++) begin
         sclk <= 1'b0;
         if (k < nTx) begin
            mosi <= tx[nTx - 1 - k];
         end else begin
            mosiEn <= 1'b0;
         end
         repeat (4) @(negedge clk);
         sclk <= 1'b1;
         repeat (4) @(negedge clk);
         r1 = {r1[62:0], miso};
         r0 = {r0[62:0], lane0};
      end
      sclk <= cpol;
      repeat (4) @(negedge clk);
      csN <= 1'b1;
      mosiEn <= 1'b1;
      repeat (12) @(negedge clk);
   endtask
endmodule

// ==== test/tb_serial_flash_write_protect.sv ====
// Self-checking bench for the serial flash write-protect core
`timescale 1ns/1ns
module tb_serial_flash_write_protect;
   localparam int SW_CYCLES = 200;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic writeGuardN = 1'b1;
   logic opDone = 1'b0;
   logic [5:0] nvCells = 6'h00;
   logic csN, sclk, mosi, mosiEn, lane0Out, lane0Oe, lane1Out, lane1Oe, lane0Wire, lane1Wire;
   logic deepPowerDown, opStart;
   logic [7:0] statusOut, readByte;
   logic [2:0] opKind;
   logic [23:0] opAddr, readAddr;
   logic [63:0] r1, r0;
   int mismatches = 0;
   int nChecks = 0;
   int doneCnt = 0;
   int nStarts = 0;
   always #5 clk = ~clk;
   // Released lines show the inverse of their last level, so a stale copy cannot pass
   assign lane0Wire = lane0Oe ? lane0Out : (mosiEn ? mosi : ~mosi);
   assign lane1Wire = lane1Oe ? lane1Out : ~lane1Out;
   assign readByte = readAddr[7:0] ^ 8'h5A;
   always @(negedge clk) begin
      opDone <= (doneCnt == 1);
      if (opStart === 1'b1) begin
         doneCnt <= 12;
         nStarts <= nStarts + 1;
      end else if (doneCnt != 0) begin
         doneCnt <= doneCnt - 1;
      end
   end
   sfwp_core #(.DENSITY_4M(1'b1), .STATUS_WRITE_CYCLES(SW_CYCLES)) u_sfwp_core (.clk(clk), .rst(rst), .ce(1'b1),
      .csN(csN), .sclk(sclk), .dualLane0In(lane0Wire), .dualLane0Out(lane0Out), .dualLane0Oe(lane0Oe),
      .dualLane1Out(lane1Out), .dualLane1Oe(lane1Oe), .writeGuardN(writeGuardN), .nvCellsIn(nvCells),
      .statusOut(statusOut), .opStart(opStart), .opKind(opKind), .opAddr(opAddr), .opDone(opDone),
      .readAddr(readAddr), .readByte(readByte), .deepPowerDown(deepPowerDown));
   sfwp_host_model u_sfwp_host_model (.clk(clk), .csN(csN), .sclk(sclk), .mosi(mosi), .mosiEn(mosiEn),
      .miso(lane1Wire), .lane0(lane0Wire));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cmd(input logic [63:0] bits, input int n);
      u_sfwp_host_model.xfer(bits, n, n, r1, r0);
   endtask
   task automatic read_status(input logic [7:0] exp);
      u_sfwp_host_model.xfer(64'h05, 8, 16, r1, r0);
      check("spi status", r1[7:0], exp);
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      while (statusOut[0] !== 1'b0 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      check("idle reached", n < 2000, 1'b1);
   endtask
   task automatic t_latch;
      check("status after reset", statusOut, 8'h00);
      read_status(8'h00);
      cmd({8'h01, 8'h04}, 16);
      check("write without latch", statusOut, 8'h00);
      u_sfwp_host_model.cpol = 1'b1;
      cmd(8'h06, 8);
      check("latch set idle high", statusOut, 8'h02);
      u_sfwp_host_model.cpol = 1'b0;
      cmd(8'h04, 8);
      check("latch cleared", statusOut, 8'h00);
   endtask
   task automatic t_status_write;
      cmd(8'h06, 8);
      cmd({8'h01, 8'h07}, 16);
      check("busy during write", statusOut[0], 1'b1);
      read_status(8'h03);
      wait_idle;
      check("region written", statusOut, 8'h04);
   endtask
   task automatic t_program;
      cmd(8'h06, 8);
      cmd({8'h02, 24'h000100, 8'hAB}, 40);
      check("protected program", nStarts, 0);
      check("latch kept", statusOut, 8'h06);
      cmd(8'hC7, 8);
      check("full clear refused", nStarts, 0);
      cmd({8'h02, 24'h07E000, 8'hAB}, 40);
      check("program started", nStarts, 1);
      check("program kind addr", {opKind, opAddr}, {3'h0, 24'h07E000});
      wait_idle;
      check("latch after program", statusOut, 8'h04);
      u_sfwp_host_model.xfer({8'h3B, 24'h000010, 8'h00}, 40, 44, r1, r0);
      check("dual byte", {r1[3], r0[3], r1[2], r0[2], r1[1], r0[1], r1[0], r0[0]}, 8'h10 ^ 8'h5A);
   endtask
   task automatic t_lock;
      cmd(8'h06, 8);
      cmd({8'h01, 8'h84}, 16);
      wait_idle;
      check("lock set", statusOut, 8'h84);
      writeGuardN = 1'b0;
      cmd(8'h06, 8);
      cmd({8'h01, 8'h00}, 16);
      wait_idle;
      check("locked write refused", statusOut, 8'h86);
      writeGuardN = 1'b1;
      cmd({8'h01, 8'h00}, 16);
      wait_idle;
      check("unlocked write taken", statusOut, 8'h00);
   endtask
   task automatic t_sleep;
      cmd(8'hB9, 8);
      check("sleep entered", deepPowerDown, 1'b1);
      cmd(8'h06, 8);
      check("unlock ignored asleep", statusOut, 8'h00);
      cmd(8'hAB, 8);
      check("woken", deepPowerDown, 1'b0);
      cmd(8'h06, 8);
      cmd(8'h60, 8);
      check("full clear started", nStarts, 2);
      check("full clear kind", opKind, 3'h4);
      wait_idle;
      check("latch after clear", statusOut, 8'h00);
   endtask
   task automatic t_reload;
      nvCells = 6'h09;
      rst = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (10) @(negedge clk);
      check("cells loaded", statusOut, 8'h24);
      cmd(8'h06, 8);
      cmd({8'hD8, 24'h070000}, 32);
      check("top block refused", nStarts, 2);
      check("latch kept top", statusOut, 8'h26);
      cmd({8'h20, 24'h07D000}, 32);
      check("sector started", {opKind, opAddr}, {3'h1, 24'h07D000});
      wait_idle;
      check("sector count", nStarts, 3);
      check("latch after sector", statusOut, 8'h24);
   endtask
   task automatic end_sim;
      $display("Checks %0d mismatches %0d", nChecks, mismatches);
      if (mismatches == 0 && nChecks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      repeat (10) @(negedge clk);
      t_latch;
      t_status_write;
      t_program;
      t_lock;
      t_sleep;
      t_reload;
      end_sim;
   end
   initial begin
      #200000;
      mismatches++;
      end_sim;
   end
endmodule
